//--- common/arf_pkg.sv
// shared constants for the converter result queue and prescaler block
package arf_pkg;

  // bus and result widths
  localparam int ARF_DW  = 16;
  localparam int ARF_AW  = 18;
  localparam int ARF_BEW = 2;
  localparam int ARF_RW  = 10;

  // register indices; the byte address is four times the index
  localparam logic [15:0] ARF_IDX_ENA  = 16'h7032;
  localparam logic [15:0] ARF_IDX_CTL2 = 16'h7034;
  localparam logic [15:0] ARF_IDX_RES1 = 16'h7036;
  localparam logic [15:0] ARF_IDX_RES2 = 16'h7038;

  // field positions in control two, in the enable register and in the result registers
  localparam int ARF_PSC_LSB = 0;
  localparam int ARF_PSC_W   = 3;
  localparam int ARF_RSV_BIT = 5;
  localparam int ARF_Q1_LSB  = 3;
  localparam int ARF_Q2_LSB  = 6;
  localparam int ARF_EN1_BIT = 0;
  localparam int ARF_EN2_BIT = 1;
  localparam int ARF_RES_LSB = 6;

  // values after reset
  localparam logic [2:0]  ARF_PSC_RST = 3'h0;
  localparam logic [1:0]  ARF_EN_RST  = 2'h0;
  localparam logic [15:0] ARF_DAT_RST = 16'h0000;

  // queue occupancy codes
  localparam logic [1:0] ARF_Q_EMPTY = 2'h0;
  localparam logic [1:0] ARF_Q_ONE   = 2'h1;
  localparam logic [1:0] ARF_Q_TWO   = 2'h2;
  localparam logic [1:0] ARF_Q_LOST  = 2'h3;

  // prescale ratio per select code, in system clock cycles
  localparam int ARF_DIVW = 6;
  localparam logic [5:0] ARF_DIV_TAB [0:7] = '{6'h04, 6'h06, 6'h08, 6'h0a,
                                               6'h0c, 6'h10, 6'h14, 6'h20};

endpackage : arf_pkg

//--- hdl/arf_prescaler.sv
// converter input clock prescaler, one-cycle enable output
`timescale 1ns/1ns
module arf_prescaler
  import arf_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       nrst_i,
  input  wire logic [2:0] sel_i,
  output logic            tick_o
);
  logic [ARF_DIVW-1:0] cnt_r;
  logic                tick_r;
  wire  [ARF_DIVW-1:0] last = ARF_DIV_TAB[sel_i] - 6'h01;
  // >= so a shorter ratio chosen mid-count ends at once
  wire                 wrap = (cnt_r >= last);

  // divider counter and registered pulse
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= wrap ? '0 : cnt_r + 6'h01;
      tick_r <= wrap;
    end
  end

  assign tick_o = tick_r;
endmodule : arf_prescaler

//--- hdl/arf_queue.sv
// two-entry result queue with overwrite of the oldest entry
`timescale 1ns/1ns
module arf_queue
  import arf_pkg::*;
#(
  parameter int W = 10
) (
  input  wire logic         clk_sys_i,
  input  wire logic         nrst_i,
  input  wire logic         push_i,
  input  wire logic [W-1:0] data_i,
  input  wire logic         pop_i,
  output logic [1:0]        status_o,
  output logic [W-1:0]      head_o
);
  logic [W-1:0] mem_r [0:1];
  logic [W-1:0] mem_nxt [0:1];
  logic [1:0]   cnt_r, cnt_nxt;
  logic         lost_r, lost_nxt;
  wire          do_pop = pop_i && (cnt_r != 2'h0);

  // next state; a pop and a push together never lose data
  always_comb begin
    mem_nxt[0] = mem_r[0];
    mem_nxt[1] = mem_r[1];
    cnt_nxt    = cnt_r;
    lost_nxt   = lost_r;
    case ({push_i, do_pop})
      2'b01: begin
        mem_nxt[0] = mem_r[1];
        cnt_nxt    = cnt_r - 2'h1;
        lost_nxt   = 1'b0;
      end
      2'b10: begin
        if (cnt_r == 2'h2) begin
          mem_nxt[0] = mem_r[1]; // oldest dropped
          mem_nxt[1] = data_i;
          lost_nxt   = 1'b1;
        end else begin
          mem_nxt[cnt_r[0]] = data_i;
          cnt_nxt           = cnt_r + 2'h1;
        end
      end
      2'b11: begin
        mem_nxt[0] = (cnt_r == 2'h1) ? data_i : mem_r[1];
        mem_nxt[1] = data_i;
        lost_nxt   = 1'b0;
      end
      default: ;
    endcase
  end

  // entries clear to zero at reset
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      mem_r[0] <= '0;
      mem_r[1] <= '0;
      cnt_r    <= 2'h0;
      lost_r   <= 1'b0;
    end else begin
      mem_r  <= mem_nxt;
      cnt_r  <= cnt_nxt;
      lost_r <= lost_nxt;
    end
  end

  assign status_o = lost_r ? ARF_Q_LOST : cnt_r;
  assign head_o   = (cnt_r == 2'h0) ? '0 : mem_r[0];
endmodule : arf_queue

//--- hdl/arf_top.sv
// converter result queues, queue status and prescaler behind an avalon slave
// Operation
// - queue one occupancy as two-bit code
// - status fields reflect queue state immediately
// - two entries kept, third drops oldest
// - select codes divide by 4..32
// - result registers read-only, zero after reset
// - result left-justified, bits 15 to 6
// - low six result bits read zero
// - control two bit 5 reserved
// - result queues at 7036h and 7038h
// - queue two status in bits 7-6
// - disabled converter two leaves queue unchanged
`timescale 1ns/1ns
module arf_top
  import arf_pkg::*;
(
  input  wire logic                         clk_sys_i,
  input  wire logic                         nrst_i,
  input  wire logic [arf_pkg::ARF_AW-1:0]   avs_address_i,
  input  wire logic                         avs_read_i,
  input  wire logic                         avs_write_i,
  input  wire logic [arf_pkg::ARF_DW-1:0]   avs_writedata_i,
  input  wire logic [arf_pkg::ARF_BEW-1:0]  avs_byteenable_i,
  output logic      [arf_pkg::ARF_DW-1:0]   avs_readdata_o,
  output logic                              avs_waitrequest_o,
  input  wire logic                         converter_one_done_i,
  input  wire logic [arf_pkg::ARF_RW-1:0]   converter_one_data_i,
  input  wire logic                         converter_two_done_i,
  input  wire logic [arf_pkg::ARF_RW-1:0]   converter_two_data_i,
  output logic                              converter_one_enable_o,
  output logic                              converter_two_enable_o,
  output logic                              conv_clk_tick_o
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  typedef enum logic {ARF_ST_IDLE, ARF_ST_ACK} arf_bus_st_t;

  arf_bus_st_t         state_r, state_nxt;
  logic                wait_r;
  logic [ARF_DW-1:0]   rdata_r, rdata_nxt;
  logic [2:0]          conv_clock_divider_sel_r;
  logic [2:0]          conv_clock_divider_sel_nxt;
  logic [1:0]          en_r, en_nxt;
  logic [1:0]          q1_stat, q2_stat;
  logic [ARF_RW-1:0]   q1_head, q2_head;
  logic                tick;

  ////////////////////////////////////////////////////////////////////////
  // address decode

  wire [ARF_AW-1:0] a_ena  = {ARF_IDX_ENA, 2'h0};
  wire [ARF_AW-1:0] a_ctl2 = {ARF_IDX_CTL2, 2'h0};
  wire [ARF_AW-1:0] a_res1 = {ARF_IDX_RES1, 2'h0};
  wire [ARF_AW-1:0] a_res2 = {ARF_IDX_RES2, 2'h0};

  // one request taken per idle cycle
  wire take   = (state_r == ARF_ST_IDLE) && (avs_read_i || avs_write_i);
  wire rd_tk  = take && avs_read_i;
  wire wr_tk  = take && avs_write_i;
  wire lo_be  = avs_byteenable_i[0];

  wire hit_ena  = (avs_address_i == a_ena);
  wire hit_ctl2 = (avs_address_i == a_ctl2);
  wire hit_res1 = (avs_address_i == a_res1);
  wire hit_res2 = (avs_address_i == a_res2);

  ////////////////////////////////////////////////////////////////////////
  // converter side: pushes and pops

  // push on the very cycle the core reports completion
  wire push1 = converter_one_done_i && en_r[ARF_EN1_BIT];
  // a disabled converter two never reaches its queue
  wire push2 = converter_two_done_i && en_r[ARF_EN2_BIT];

  // a read pops; a write to a result address only completes
  wire pop1 = rd_tk && hit_res1;
  wire pop2 = rd_tk && hit_res2;

  arf_queue #(
    .W (ARF_RW)
  ) u_q1 (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .push_i    (push1),
    .data_i    (converter_one_data_i),
    .pop_i     (pop1),
    .status_o  (q1_stat),
    .head_o    (q1_head)
  );

  arf_queue #(
    .W (ARF_RW)
  ) u_q2 (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .push_i    (push2),
    .data_i    (converter_two_data_i),
    .pop_i     (pop2),
    .status_o  (q2_stat),
    .head_o    (q2_head)
  );

  arf_prescaler u_psc (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .sel_i     (conv_clock_divider_sel_r),
    .tick_o    (tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // read data selection

  // results left-justified, low six bits forced to zero
  wire [ARF_DW-1:0] res1_word = {q1_head, 6'h00};
  wire [ARF_DW-1:0] res2_word = {q2_head, 6'h00};

  // live status, no shadow; bit 5 and upper byte read zero
  wire [ARF_DW-1:0] ctl2_word = {8'h00, q2_stat, 1'b0, q1_stat,
                                 conv_clock_divider_sel_r};
  wire [ARF_DW-1:0] ena_word  = {14'h0000, en_r};

  // unmapped addresses answer zero
  wire [ARF_DW-1:0] rd_mux = hit_res1 ? res1_word :
                             hit_res2 ? res2_word :
                             hit_ctl2 ? ctl2_word :
                             hit_ena  ? ena_word  : ARF_DAT_RST;

  ////////////////////////////////////////////////////////////////////////
  // register writes

  // in control two only the select field is writable; status and bit 5 ignore writes
  assign conv_clock_divider_sel_nxt = (wr_tk && hit_ctl2 && lo_be) ?
    avs_writedata_i[ARF_PSC_LSB +: ARF_PSC_W] :
    conv_clock_divider_sel_r;

  assign en_nxt = (wr_tk && hit_ena && lo_be) ?
    {avs_writedata_i[ARF_EN2_BIT], avs_writedata_i[ARF_EN1_BIT]} :
    en_r;

  ////////////////////////////////////////////////////////////////////////
  // bus answer sequencer

  // every request answered one cycle after it is taken
  always_comb begin
    state_nxt = state_r;
    rdata_nxt = rdata_r;
    case (state_r)
      ARF_ST_IDLE: begin
        if (take) begin
          state_nxt = ARF_ST_ACK;
          rdata_nxt = avs_read_i ? rd_mux : ARF_DAT_RST;
        end
      end
      ARF_ST_ACK: begin
        state_nxt = ARF_ST_IDLE;
      end
      default: begin
        state_nxt = ARF_ST_IDLE;
      end
    endcase
  end

  // sequencer and read data flops
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      state_r <= ARF_ST_IDLE;
      wait_r  <= 1'b1;
      rdata_r <= ARF_DAT_RST;
    end else begin
      state_r <= state_nxt;
      wait_r  <= (state_nxt != ARF_ST_ACK);
      rdata_r <= rdata_nxt;
    end
  end

  // control flops
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      conv_clock_divider_sel_r <= ARF_PSC_RST;
      en_r                     <= ARF_EN_RST;
    end else begin
      conv_clock_divider_sel_r <= conv_clock_divider_sel_nxt;
      en_r                     <= en_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign avs_readdata_o         = rdata_r;
  assign avs_waitrequest_o      = wait_r;
  assign converter_one_enable_o = en_r[ARF_EN1_BIT];
  assign converter_two_enable_o = en_r[ARF_EN2_BIT];
  assign conv_clk_tick_o        = tick;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking arf_cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);

  // helper: cycles since last tick, and a quiet-select marker
  logic [ARF_DIVW-1:0] gap_r;
  logic                calm_r;
  wire                 psc_wr = wr_tk && hit_ctl2 && lo_be;

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      gap_r  <= '0;
      calm_r <= 1'b0;
    end else begin
      gap_r  <= tick ? '0 : gap_r + 6'h01;
      calm_r <= psc_wr ? 1'b0 : (tick ? 1'b1 : calm_r);
    end
  end

  property p_q1_code;
    (q1_stat == ARF_Q_EMPTY) && push1 && !pop1
      |=> (q1_stat == ARF_Q_ONE);
  endproperty
  a_q1_code: assert property (p_q1_code)
    else $error("queue one did not report one entry");

  property p_status_live;
    rd_tk && hit_ctl2
      |=> (avs_readdata_o[ARF_Q1_LSB +: 2] == $past(q1_stat))
          && (avs_readdata_o[ARF_Q2_LSB +: 2] == $past(q2_stat));
  endproperty
  a_status_live: assert property (p_status_live)
    else $error("status read did not show current queue state");

  property p_overflow;
    (q1_stat == ARF_Q_TWO) && push1 && !pop1
      |=> (q1_stat == ARF_Q_LOST) ##1 ((q1_stat == ARF_Q_LOST) || $past(pop1));
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("third result did not flag loss");

  property p_div_ratio;
    tick && calm_r && !$past(psc_wr)
      |-> (gap_r == ARF_DIV_TAB[conv_clock_divider_sel_r] - 6'h01);
  endproperty
  a_div_ratio: assert property (p_div_ratio)
    else $error("prescaler period does not match select");

  property p_res_ro;
    wr_tk && hit_res1 && !push1 |=> $stable(q1_stat);
  endproperty
  a_res_ro: assert property (p_res_ro)
    else $error("write changed result queue");

  property p_res_word;
    rd_tk && hit_res2 |=> avs_readdata_o == {$past(q2_head), 6'h00};
  endproperty
  a_res_word: assert property (p_res_word)
    else $error("result word not left-justified");

  property p_rsv_bit;
    rd_tk && hit_ctl2 |=> !avs_readdata_o[ARF_RSV_BIT];
  endproperty
  a_rsv_bit: assert property (p_rsv_bit)
    else $error("reserved bit read nonzero");

  property p_answer;
    take |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
  endproperty
  a_answer: assert property (p_answer)
    else $error("bus answer not one cycle after request");

  property p_q2_off;
    !en_r[ARF_EN2_BIT] && !pop2 |=> $stable(q2_stat);
  endproperty
  a_q2_off: assert property (p_q2_off)
    else $error("disabled converter two changed its queue");

  property p_pop;
    rd_tk && hit_res1 && (q1_stat == ARF_Q_ONE) && !push1
      |=> (q1_stat == ARF_Q_EMPTY);
  endproperty
  a_pop: assert property (p_pop)
    else $error("result read did not pop queue one");

  property p_push_now;
    push2 && (q2_stat == ARF_Q_EMPTY) && !pop2
      |=> (q2_stat == ARF_Q_ONE);
  endproperty
  a_push_now: assert property (p_push_now)
    else $error("completion not pushed the same cycle");

  property p_tick_pulse;
    tick |=> !tick;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse)
    else $error("converter clock tick longer than one cycle");

  property p_wait_idle;
    !take |=> avs_waitrequest_o;
  endproperty
  a_wait_idle: assert property (p_wait_idle)
    else $error("bus answered without a request");

  property p_sel_wr;
    psc_wr
      |=> (conv_clock_divider_sel_r == $past(avs_writedata_i[ARF_PSC_LSB +: ARF_PSC_W]));
  endproperty
  a_sel_wr: assert property (p_sel_wr)
    else $error("select field did not take the written code");

  property p_q2_lost;
    (q2_stat == ARF_Q_TWO) && push2 && !pop2
      |=> (q2_stat == ARF_Q_LOST);
  endproperty
  a_q2_lost: assert property (p_q2_lost)
    else $error("third result did not flag loss on queue two");

  property p_res1_word;
    rd_tk && hit_res1 |=> avs_readdata_o == {$past(q1_head), 6'h00};
  endproperty
  a_res1_word: assert property (p_res1_word)
    else $error("queue one word not left-justified");

  property p_pop2;
    rd_tk && hit_res2 && (q2_stat == ARF_Q_ONE) && !push2
      |=> (q2_stat == ARF_Q_EMPTY);
  endproperty
  a_pop2: assert property (p_pop2)
    else $error("result read did not pop queue two");

  property p_res2_ro;
    wr_tk && hit_res2 && !push2 |=> $stable(q2_stat);
  endproperty
  a_res2_ro: assert property (p_res2_ro)
    else $error("write changed queue two");

  property p_lost_pop;
    (q1_stat == ARF_Q_LOST) && pop1 && !push1
      |=> (q1_stat == ARF_Q_ONE);
  endproperty
  a_lost_pop: assert property (p_lost_pop)
    else $error("pop after loss did not leave one entry");

endmodule : arf_top

//--- tb/arf_conv_model.sv
// behavioural converter core: one result per start, after some converter clock ticks
`timescale 1ns/1ns
module arf_conv_model (
  input  wire logic       clk_sys_i,
  input  wire logic       nrst_i,
  input  wire logic       tick_i,
  input  wire logic       start_i,
  input  wire logic [9:0] value_i,
  input  wire logic [3:0] ticks_i,
  output logic            done_o,
  output logic [9:0]      data_o
);
  logic       busy_r;
  logic [3:0] cnt_r;
  logic [9:0] val_r;
  //////////////////////////////////////////
  // result bus is only valid with done; otherwise show the inverse so nothing leans on it
  always_ff @(posedge clk_sys_i) begin
    done_o <= 1'b0;
    data_o <= ~val_r;
    if (!nrst_i) begin
      busy_r <= 1'b0;
      cnt_r  <= 4'h0;
      val_r  <= 10'h000;
    end else if (start_i) begin
      busy_r <= 1'b1;
      cnt_r  <= ticks_i;
      val_r  <= value_i;
    end else if (busy_r && cnt_r == 4'h0) begin
      busy_r <= 1'b0;
      done_o <= 1'b1;
      data_o <= val_r;
    end else if (busy_r && tick_i) begin
      cnt_r <= cnt_r - 4'h1; // slow answer: waits on converter clock
    end
  end
endmodule : arf_conv_model

//--- tb/tb_top.sv
// self-checking bench for the result queues, queue status and prescaler
`timescale 1ns/1ns
module tb_top;
  import arf_pkg::*;
  logic              clk_sys_i;
  logic              nrst_i;
  logic [ARF_AW-1:0] avs_address_i;
  logic              avs_read_i;
  logic              avs_write_i;
  logic [ARF_DW-1:0] avs_writedata_i;
  logic [ARF_DW-1:0] avs_readdata_o;
  logic              avs_waitrequest_o;
  logic [1:0]        st;
  logic [9:0]        val [2];
  logic [3:0]        tks [2];
  wire  [1:0]        dn;
  wire  [1:0][9:0]   cd;
  logic              en1;
  logic              en2;
  logic              tick;
  logic [15:0]       d;
  logic [31:0]       rs;
  int                fails;
  int                checked;
  //////////////////////////////////////////
  arf_top DUT (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(2'h3), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .converter_one_done_i(dn[0]), .converter_one_data_i(cd[0]), .converter_two_done_i(dn[1]),
    .converter_two_data_i(cd[1]), .converter_one_enable_o(en1), .converter_two_enable_o(en2),
    .conv_clk_tick_o(tick));
  arf_conv_model conv_one (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .tick_i(tick), .start_i(st[0]),
    .value_i(val[0]), .ticks_i(tks[0]), .done_o(dn[0]), .data_o(cd[0]));
  arf_conv_model conv_two (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .tick_i(tick), .start_i(st[1]),
    .value_i(val[1]), .ticks_i(tks[1]), .done_o(dn[1]), .data_o(cd[1]));
  // 25 MHz system clock
  always #20 clk_sys_i = ~clk_sys_i;
  //////////////////////////////////////////
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd
  function automatic logic [15:0] ctl(input logic [1:0] q1, input logic [1:0] q2, input logic [2:0] s);
    return {8'h00, q2, 1'b0, q1, s};
  endfunction : ctl
  function automatic logic [15:0] qst(input int k, input logic [1:0] q);
    return (k == 0) ? ctl(q, 2'h0, 3'h0) : ctl(2'h0, q, 3'h0);
  endfunction : qst
  function automatic logic [15:0] ridx(input int k);
    return (k == 0) ? 16'h7036 : 16'h7038;
  endfunction : ridx
  function automatic logic [15:0] div(input logic [2:0] c);
    logic [15:0] t [8];
    t = '{16'h04, 16'h06, 16'h08, 16'h0a, 16'h0c, 16'h10, 16'h14, 16'h20};
    return t[c];
  endfunction : div
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    $display("counts: checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic tmo();
    fails++;
    $display("mismatch wait expected %h seen %h", 1'b1, 1'b0);
    summarize();
  endtask : tmo
  // one avalon transfer; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [15:0] wd, output logic [15:0] rd);
    int i;
    @(posedge clk_sys_i);
    avs_address_i   <= {idx, 2'b00};
    avs_write_i     <= wr;
    avs_read_i      <= ~wr;
    avs_writedata_i <= wd;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    if (i == 20) tmo();
    rd = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus
  // one conversion on converter k, prompt or a few ticks late
  task automatic push(input int k, input logic [9:0] v);
    int i;
    @(posedge clk_sys_i);
    st[k]  <= 1'b1;
    val[k] <= v;
    tks[k] <= 4'(rnd() & 32'h3);
    @(posedge clk_sys_i);
    st[k] <= 1'b0;
    for (i = 0; i < 200; i++) begin
      @(posedge clk_sys_i);
      if (dn[k] === 1'b1) break;
    end
    if (i == 200) tmo();
  endtask : push
  // cycles in one full prescaler period, the third one measured; the first one after a change may be short
  task automatic per(output logic [15:0] n);
    int i;
    int j;
    n = 16'h0;
    for (j = 0; j < 3; j++) begin
      n = 16'h0;
      for (i = 0; i < 100; i++) begin
        @(posedge clk_sys_i);
        n = n + 16'h1;
        if (tick === 1'b1) break;
      end
      if (i == 100) tmo();
    end
  endtask : per
  //////////////////////////////////////////
  initial begin
    logic [9:0] a;
    logic [9:0] b;
    logic [9:0] c;
    int k;
    clk_sys_i = 1'b0;
    nrst_i = 1'b0;
    avs_address_i = '0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 16'h0;
    st = 2'h0;
    val = '{10'h0, 10'h0};
    tks = '{4'h0, 4'h0};
    fails = 0;
    checked = 0;
    rs = 32'ha145;
    repeat (12) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    // reset values, read-only results, unmapped place
    bus(1'b0, ARF_IDX_CTL2, 16'h0, d);
    chk("status reset", d, 16'h0000);
    bus(1'b0, ARF_IDX_RES1, 16'h0, d);
    chk("result one reset", d, 16'h0000);
    bus(1'b1, ARF_IDX_RES1, 16'hffff, d);
    chk("write answer", d, 16'h0000);
    bus(1'b1, ARF_IDX_RES2, 16'hffff, d);
    bus(1'b0, ARF_IDX_RES2, 16'h0, d);
    chk("result two written", d, 16'h0000);
    bus(1'b0, 16'h7000, 16'h0, d);
    chk("unmapped read", d, 16'h0000);
    bus(1'b1, ARF_IDX_ENA, 16'h0003, d);
    chk("enables", {14'h0, en2, en1}, 16'h0003);
    $display("test reset_access done");
    // third result drops the oldest; drain past empty
    for (k = 0; k < 2; k++) begin
      a = 10'(rnd());
      b = (k == 0) ? 10'h3ff : 10'(rnd());
      c = (k == 0) ? 10'h001 : 10'(rnd());
      push(k, a);
      push(k, b);
      push(k, c);
      bus(1'b0, ARF_IDX_CTL2, 16'h0, d);
      chk("status lost", d, qst(k, ARF_Q_LOST));
      bus(1'b0, ridx(k), 16'h0, d);
      chk("oldest kept", d, {b, 6'h00});
      bus(1'b0, ARF_IDX_CTL2, 16'h0, d);
      chk("status after pop", d, qst(k, ARF_Q_ONE));
      bus(1'b0, ridx(k), 16'h0, d);
      chk("newest", d, {c, 6'h00});
      bus(1'b0, ARF_IDX_CTL2, 16'h0, d);
      chk("status drained", d, 16'h0000);
      bus(1'b0, ridx(k), 16'h0, d);
      chk("empty read", d, 16'h0000);
    end
    $display("test overflow done");
    // status is read right after the first and the third push; each converter feeds its own queue
    a = 10'(rnd());
    b = 10'(rnd());
    c = 10'(rnd());
    push(0, a);
    bus(1'b0, ARF_IDX_CTL2, 16'h0, d);
    chk("status one entry", d, ctl(ARF_Q_ONE, 2'h0, 3'h0));
    push(0, b);
    push(1, c);
    bus(1'b0, ARF_IDX_CTL2, 16'h0, d);
    chk("status two and one", d, ctl(ARF_Q_TWO, ARF_Q_ONE, 3'h0));
    bus(1'b0, ARF_IDX_RES1, 16'h0, d);
    chk("queue one first", d, {a, 6'h00});
    bus(1'b0, ARF_IDX_RES1, 16'h0, d);
    chk("queue one second", d, {b, 6'h00});
    bus(1'b0, ARF_IDX_RES2, 16'h0, d);
    chk("queue two", d, {c, 6'h00});
    $display("test live_status done");
    // converter two disabled: its done is ignored
    bus(1'b1, ARF_IDX_ENA, 16'h0001, d);
    chk("enable two off", {14'h0, en2, en1}, 16'h0001);
    push(1, a);
    bus(1'b0, ARF_IDX_CTL2, 16'h0, d);
    chk("status disabled", d, 16'h0000);
    bus(1'b0, ARF_IDX_RES2, 16'h0, d);
    chk("result disabled", d, 16'h0000);
    $display("test disabled done");
    // mid-run reset must empty a loaded queue and drop the enables
    push(0, b);
    bus(1'b0, ARF_IDX_CTL2, 16'h0, d);
    chk("status before reset", d, ctl(ARF_Q_ONE, 2'h0, 3'h0));
    @(posedge clk_sys_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    chk("enables after reset", {14'h0, en2, en1}, 16'h0000);
    bus(1'b0, ARF_IDX_CTL2, 16'h0, d);
    chk("status after reset", d, 16'h0000);
    bus(1'b0, ARF_IDX_RES1, 16'h0, d);
    chk("result after reset", d, 16'h0000);
    $display("test mid_reset done");
    // every select code, with reserved and status bits written as ones
    for (k = 0; k < 8; k++) begin
      bus(1'b1, ARF_IDX_CTL2, {8'(rnd()), 5'h1f, 3'(k)}, d);
      bus(1'b0, ARF_IDX_CTL2, 16'h0, d);
      chk("select readback", d, ctl(2'h0, 2'h0, 3'(k)));
      per(d);
      chk("prescale period", d, div(3'(k)));
    end
    $display("test prescaler done");
    summarize();
  end
endmodule : tb_top
